// *** rtl/ptt_event_if.sv ***
// Interface carrying the event strobes between counter and flag logic.
// Assumes one clock domain.
`timescale 1ns/10ps
interface ptt_event_if #(parameter int N = 4);
	logic [N-1:0] evPulse; // One-cycle event strobes
	logic [N-1:0] clrMask; // Write-one-to-clear mask, one cycle
	logic clrValid; // Clear mask is valid this cycle
	logic [N-1:0] flags; // Sticky flags
	modport src(output evPulse, output clrMask, output clrValid, input flags);
	modport dst(input evPulse, input clrMask, input clrValid, output flags);
endinterface

// *** rtl/ptt_flag_bit.sv ***
// One sticky event flag with write-one clear; set wins over clear.
// Assumes single clock, synchronised reset.
`timescale 1ns/10ps
module ptt_flag_bit (
	input wire logic clk, // Core clock
	input wire logic rstN, // Synchronised reset, active low
	input wire logic setPulse, // Event occurred
	input wire logic clrPulse, // Software wrote one
	output logic flag // Sticky flag
);
	// Set has priority so an event in the clear cycle is kept
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			flag <= 1'b0;
		end else if (setPulse) begin
			flag <= 1'b1;
		end else if (clrPulse) begin
			flag <= 1'b0;
		end
	end
endmodule // ptt_flag_bit

// *** rtl/ptt_pkg.sv ***
// Package of constants for the periodic tick timer.
// Assumes an 8-bit register port with byte addresses as offsets.
// Operation
// - Counter advances only while run bit set
// - Count register is read-only, resets to zero
// - 32 Hz request gated by its enable
// - 8 Hz request gated by its enable
// - 2 Hz request gated by its enable
// - 1 Hz request gated by its enable
// - Sticky event flags, cleared by writing one
package ptt_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int NUM_EV = 4;
	localparam logic [15:0] OFF_CTRL = 16'h5000;
	localparam logic [15:0] OFF_COUNT = 16'h5001;
	localparam logic [15:0] OFF_MASK = 16'h5002;
	localparam logic [15:0] OFF_FLAGS = 16'h5003;
	localparam int BIT_RUN = 0;
	localparam int BIT_CLEAR = 4;
	localparam int BIT_EV32 = 3;
	localparam int BIT_EV8 = 2;
	localparam int BIT_EV2 = 1;
	localparam int BIT_EV1 = 0;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [3:0] RST_MASK = 4'h0;
	localparam logic [3:0] RST_FLAGS = 4'h0;
	// Counter bits whose falling edge marks 32, 8, 2 and 1 Hz (256 Hz input)
	localparam int TAP32 = 2;
	localparam int TAP8 = 4;
	localparam int TAP2 = 6;
	localparam int TAP1 = 7;
	// Input count tick rate; one tick is a 256 Hz period
	localparam int TICK_HZ = 256;
	localparam int CLK_HZ = 100000000;
	localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
endpackage

// *** rtl/ptt_timer.sv ***
// Top of the periodic tick timer: register port, count, events, flags.
// Assumes a 100 MHz core clock; the 256 Hz tick is made from it.
`timescale 1ns/10ps
module ptt_timer #(
	parameter int TICK_CYCLES = ptt_pkg::TICK_CYCLES
) (
	input wire logic core_clk, // Core clock, 100 MHz
	input wire logic nrst, // Asynchronous reset, active low
	input wire logic [15:0] regAddr, // Register byte address
	input wire logic [7:0] regWrData, // Write data
	input wire logic regWr, // Write strobe
	input wire logic regRd, // Read strobe
	output logic [7:0] regRdData_q, // Read data, cycle after strobe
	output logic [3:0] evIrq_q // Enabled interrupt requests, by event
);
	// Elaboration check: a zero-length tick period cannot be counted
	if (TICK_CYCLES < 1) begin : gBadTick
		$error("TICK_CYCLES must be at least 1");
	end

	logic rstSync1_q;
	logic rstN_q;
	logic [31:0] preCnt_q;
	logic tick;
	logic run_q;
	logic [7:0] count_q;
	logic [7:0] countPrev_q;
	logic [3:0] mask_q;
	logic wrCtrl;
	logic wrMask;
	logic wrFlags;
	logic [3:0] taps;
	logic [3:0] tapsPrev;

	ptt_event_if #(.N(ptt_pkg::NUM_EV)) evBus ();

	// Reset released through two flops to avoid release races
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rstSync1_q <= 1'b0;
			rstN_q <= 1'b0;
		end else begin
			rstSync1_q <= 1'b1;
			rstN_q <= rstSync1_q;
		end
	end

	assign wrCtrl = regWr && (regAddr == ptt_pkg::OFF_CTRL);
	assign wrMask = regWr && (regAddr == ptt_pkg::OFF_MASK);
	assign wrFlags = regWr && (regAddr == ptt_pkg::OFF_FLAGS);

	// Run/stop control bit
	always_ff @(posedge core_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			run_q <= 1'b0;
		end else if (wrCtrl) begin
			run_q <= regWrData[ptt_pkg::BIT_RUN];
		end
	end

	// Prescaler makes the 256 Hz tick; it holds while stopped
	always_ff @(posedge core_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			preCnt_q <= 32'h0;
		end else if (wrCtrl && regWrData[ptt_pkg::BIT_CLEAR]) begin
			preCnt_q <= 32'h0;
		end else if (run_q) begin
			if (tick) begin
				preCnt_q <= 32'h0;
			end else begin
				preCnt_q <= preCnt_q + 32'h1;
			end
		end
	end
	assign tick = run_q && (preCnt_q == 32'(TICK_CYCLES - 1));

	// Time-base counter; clear wins over a tick in the same cycle
	always_ff @(posedge core_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			count_q <= ptt_pkg::RST_COUNT;
		end else if (wrCtrl && regWrData[ptt_pkg::BIT_CLEAR]) begin
			count_q <= 8'h00;
		end else if (tick) begin
			count_q <= count_q + 8'h01;
		end
	end

	// Previous count, so falling edges of tap bits mark the events
	always_ff @(posedge core_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			countPrev_q <= ptt_pkg::RST_COUNT;
		end else begin
			countPrev_q <= count_q;
		end
	end

	assign taps = {count_q[ptt_pkg::TAP32], count_q[ptt_pkg::TAP8],
		count_q[ptt_pkg::TAP2], count_q[ptt_pkg::TAP1]};
	assign tapsPrev = {countPrev_q[ptt_pkg::TAP32],
		countPrev_q[ptt_pkg::TAP8], countPrev_q[ptt_pkg::TAP2],
		countPrev_q[ptt_pkg::TAP1]};
	// A clear also drops taps; only a counting edge, or a clear from count 8'hff, raises an event
	assign evBus.evPulse = tapsPrev & ~taps & {4{count_q != 8'h00 ||
		countPrev_q == 8'hff}};
	assign evBus.clrMask = regWrData[3:0];
	assign evBus.clrValid = wrFlags;

	// One sticky flag per event
	for (genvar i = 0; i < ptt_pkg::NUM_EV; i++) begin : gFlag
		ptt_flag_bit uFlag (
			.clk(core_clk),
			.rstN(rstN_q),
			.setPulse(evBus.evPulse[i]),
			.clrPulse(evBus.clrValid && evBus.clrMask[i]),
			.flag(evBus.flags[i])
		);
	end

	// Event enable mask
	always_ff @(posedge core_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			mask_q <= ptt_pkg::RST_MASK;
		end else if (wrMask) begin
			mask_q <= regWrData[3:0];
		end
	end

	// Requests gated by enables; flags still set when disabled
	always_ff @(posedge core_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			evIrq_q <= 4'h0;
		end else begin
			evIrq_q[ptt_pkg::BIT_EV32] <= evBus.flags[ptt_pkg::BIT_EV32] &&
				mask_q[ptt_pkg::BIT_EV32];
			evIrq_q[ptt_pkg::BIT_EV8] <= evBus.flags[ptt_pkg::BIT_EV8] &&
				mask_q[ptt_pkg::BIT_EV8];
			evIrq_q[ptt_pkg::BIT_EV2] <= evBus.flags[ptt_pkg::BIT_EV2] &&
				mask_q[ptt_pkg::BIT_EV2];
			evIrq_q[ptt_pkg::BIT_EV1] <= evBus.flags[ptt_pkg::BIT_EV1] &&
				mask_q[ptt_pkg::BIT_EV1];
		end
	end

	// Read data; clear bit and reserved bits read zero, unmapped reads zero
	always_ff @(posedge core_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			regRdData_q <= 8'h00;
		end else if (regRd) begin
			case (regAddr)
				ptt_pkg::OFF_CTRL: regRdData_q <= {7'h00, run_q};
				ptt_pkg::OFF_COUNT: regRdData_q <= count_q;
				ptt_pkg::OFF_MASK: regRdData_q <= {4'h0, mask_q};
				ptt_pkg::OFF_FLAGS: regRdData_q <= {4'h0, evBus.flags};
				default: regRdData_q <= 8'h00;
			endcase
		end else begin
			regRdData_q <= 8'h00;
		end
	end
endmodule // ptt_timer

// *** verification/ptt_timer_monitor.sv ***
// Checker for the tick timer register port and request outputs.
// Assumes it is bound into ptt_timer and sees only its ports.
`timescale 1ns/10ps
module ptt_timer_monitor #(
	parameter int TICK_CYCLES = 4
) (
	input wire logic core_clk, // Core clock
	input wire logic nrst, // Reset, active low
	input wire logic [15:0] regAddr, // Register address
	input wire logic [7:0] regWrData, // Write data
	input wire logic regWr, // Write strobe
	input wire logic regRd, // Read strobe
	input wire logic [7:0] regRdData_q, // Read data
	input wire logic [3:0] evIrq_q // Requests
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// Read data stand one cycle, so a bus mux may OR them
	property p_rd_idle;
		!regRd |=> regRdData_q == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else
		$error("stale read data");
	property p_ctrl;
		regRd && regAddr == 16'h5000 |=> regRdData_q[7:1] == 7'h00;
	endproperty
	a_ctrl: assert property (p_ctrl) else
		$error("clear bit read back");
	property p_mask;
		regRd && regAddr == 16'h5002 |=> regRdData_q[7:4] == 4'h0;
	endproperty
	a_mask: assert property (p_mask) else
		$error("mask upper bits set");
	property p_flag;
		regRd && regAddr == 16'h5003 |=> regRdData_q[7:4] == 4'h0;
	endproperty
	a_flag: assert property (p_flag) else
		$error("flag upper bits set");
	property p_unmap;
		regRd && regAddr > 16'h5003 |=> regRdData_q == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else
		$error("unmapped read nonzero");
	// Requests drop two edges after all enables are written off
	property p_mask_off;
		regWr && regAddr == 16'h5002 && regWrData[3:0] == 4'h0
		|-> ##2 evIrq_q == 4'h0;
	endproperty
	a_mask_off: assert property (p_mask_off) else
		$error("request not masked");
	// Without writes a raised request cannot fall: flags are sticky
	property p_sticky;
		!regWr ##1 !regWr
		|=> (evIrq_q & $past(evIrq_q)) == $past(evIrq_q);
	endproperty
	a_sticky: assert property (p_sticky) else
		$error("request fell alone");
	property p_flag_rd;
		regRd && regAddr == 16'h5003 && !$past(regWr)
		|=> (regRdData_q[3:0] & $past(evIrq_q)) == $past(evIrq_q);
	endproperty
	a_flag_rd: assert property (p_flag_rd) else
		$error("flag read misses request");
	cover property (evIrq_q == 4'hf);
	cover property (regWr && regAddr == 16'h5000 && regWrData[4]);
	cover property (regRd && regAddr == 16'h5003);
endmodule // ptt_timer_monitor
bind ptt_timer ptt_timer_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
	.core_clk(core_clk),
	.nrst(nrst),
	.regAddr(regAddr),
	.regWrData(regWrData),
	.regWr(regWr),
	.regRd(regRd),
	.regRdData_q(regRdData_q),
	.evIrq_q(evIrq_q)
);

// *** verification/test_periodic_tick_timer.sv ***
// Self-checking bench for the periodic tick timer.
// Assumes the bound checker; a tick is four core cycles here.
`timescale 1ns/10ps
module test_periodic_tick_timer;
	logic core_clk, nrst, regWr, regRd;
	logic [15:0] regAddr;
	logic [7:0] regWrData, regRdData_q, d;
	logic [3:0] evIrq_q;
	int failures = 0;
	int comparisons = 0;
	ptt_timer #(.TICK_CYCLES(4)) dut (.core_clk(core_clk), .nrst(nrst),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData_q(regRdData_q), .evIrq_q(evIrq_q));
	// 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// Bus cycles: one-edge strobe, read data sampled just after it
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge core_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= v;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge core_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1 v = regRdData_q;
	endtask
	task automatic rc(input logic [15:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		chk(v, exp);
	endtask
	task automatic finish_test;
		if (failures == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Watchdog: the sequence needs about 12 us
	initial begin
		#50000;
		failures++;
		finish_test;
	end
	// Main sequence
	initial begin
		nrst = 1'b0;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 16'h0000;
		regWrData = 8'h00;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge core_clk);
		for (int i = 0; i < 5; i++) begin
			rc(16'h5000 + 16'(i), 8'h00);
		end
		wr(16'h5002, 8'hff);
		rc(16'h5002, 8'h0f);
		wr(16'h5001, 8'h55);
		rc(16'h5001, 8'h00);
		wr(16'h5000, 8'h01);
		rc(16'h5000, 8'h01);
		// Run past a full wrap so every event fires
		repeat (1100) @(posedge core_clk);
		wr(16'h5000, 8'h00);
		rc(16'h5003, 8'h0f);
		chk({4'h0, evIrq_q}, 8'h0f);
		rd(16'h5001, d);
		repeat (20) @(posedge core_clk);
		rc(16'h5001, d);
		wr(16'h5003, 8'h05);
		wr(16'h5003, 8'h00);
		rc(16'h5003, 8'h0a);
		for (int i = 0; i < 4; i++) begin
			wr(16'h5002, 8'h01 << i);
			rc(16'h5003, 8'h0a);
			chk({4'h0, evIrq_q}, (8'h01 << i) & 8'h0a);
		end
		wr(16'h5000, 8'h10);
		rc(16'h5001, 8'h00);
		rc(16'h5000, 8'h00);
		wr(16'h5003, 8'h0f);
		wr(16'h5000, 8'h11);
		repeat (20) @(posedge core_clk);
		rc(16'h5003, 8'h00);
		repeat (20) @(posedge core_clk);
		rc(16'h5003, 8'h08);
		finish_test;
	end
endmodule // test_periodic_tick_timer
